//--- power_mode_ctrl.v
// power mode and regulator control: idle, stop, suspend and regulator bits
// assumes the cpu gives a one-cycle instr_done pulse and synchronous inputs
//
// Operation
// - control bit 7 high disables the usb regulator, low enables it
// - control bit 6 is read only and shows the wake pin level
// - control bit 4 puts the usb regulator into low power suspend mode
// - control bit 3 shuts the core regulator in stop; only pin reset works
// - control bit 1 sets core regulator low power; not while usb regulator off
// - idle select halts the cpu after the writing instruction; state kept
// - enabled interrupt during idle clears idle and resumes the cpu
// - any reset ends idle, stop or suspend and restarts at address zero
// - enabled watchdog keeps running in idle and resets the device
// - stop select stops oscillator, cpu and peripherals after the instruction
// - only a reset ends stop mode; interrupts do not
// - enabled missing clock detector resets the device out of stop
// - suspend bit halts the internal oscillator after the instruction
// - wake pin edge or reset ends suspend; wake interrupt then serviced
// - idle and stop select bits always read as zero
// - wake pin interrupt on either edge, no pending flag
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_regs.vh"

module power_mode_ctrl (
   input wire clk,
   input wire nrst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire instr_done,
   input wire irq_pending,
   input wire wake_pin,
   input wire reset_pin,
   input wire watchdog_kick,
   output wire cpu_halt,
   output wire periph_clk_stop,
   output wire hf_osc_enable,
   output reg usb_regulator_enable,
   output reg usb_regulator_low_power,
   output reg core_regulator_on,
   output reg core_regulator_low_power,
   output wire wake_irq,
   output reg sys_reset,
   output wire [15:0] fetch_addr
);
   localparam [1:0] ST_RUN = `MODE_RUN;
   localparam [1:0] ST_IDLE = `MODE_IDLE;
   localparam [1:0] ST_STOP = `MODE_STOP;
   localparam [1:0] ST_SUSPEND = `MODE_SUSPEND;
   localparam integer WD_CYC = `WATCHDOG_TIMEOUT_US * `CLOCK_MHZ;
   localparam integer MCD_CYC = `MISSING_CLK_TIMEOUT_US * `CLOCK_MHZ;

   reg [7:0] reg_ctrl_q;
   reg [7:0] osc_ctrl_q;
   reg [7:0] mode_ctrl_q;
   reg idle_req_q;
   reg stop_req_q;
   reg susp_req_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg wake_prev_q;
   reg wake_irq_q;
   reg stop_shutdown_q;
   wire wr_reg_ctrl;
   wire wr_power;
   wire wr_osc;
   wire wr_mode;
   wire wake_edge;
   wire wd_expired;
   wire mcd_expired;
   wire int_reset;
   wire any_reset;
   wire [7:0] reg_ctrl_rd;
   wire [7:0] power_rd;

   assign wr_reg_ctrl = wr && (addr == `ADDR_REGULATOR_CONTROL);
   assign wr_power = wr && (addr == `ADDR_POWER_CONTROL);
   assign wr_osc = wr && (addr == `ADDR_OSCILLATOR_CONTROL);
   assign wr_mode = wr && (addr == `ADDR_MODE_CONTROL);

   // regulator control byte
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_ctrl_q <= `RESET_BYTE;
      end else if (any_reset) begin
         reg_ctrl_q <= `RESET_BYTE;
      end else if (wr_reg_ctrl) begin
         reg_ctrl_q <= wdata & `REG_CTRL_WRITE_MASK;
      end
   end

   // oscillator control byte, suspend bit is masked out and always reads as zero
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_ctrl_q <= `RESET_BYTE;
      end else if (any_reset) begin
         osc_ctrl_q <= `RESET_BYTE;
      end else if (wr_osc) begin
         osc_ctrl_q <= wdata & `OSC_CTRL_WRITE_MASK;
      end
   end

   // watchdog, missing clock detector and wake interrupt enables
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_ctrl_q <= `RESET_BYTE;
      end else if (any_reset) begin
         mode_ctrl_q <= `RESET_BYTE;
      end else if (wr_mode) begin
         mode_ctrl_q <= wdata;
      end
   end

   // mode requests wait for the writing instruction to complete
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idle_req_q <= 1'b0;
         stop_req_q <= 1'b0;
         susp_req_q <= 1'b0;
      end else if (any_reset) begin
         idle_req_q <= 1'b0;
         stop_req_q <= 1'b0;
         susp_req_q <= 1'b0;
      end else begin
         // a new request written beside instr_done wins over the clear
         if (instr_done) begin
            idle_req_q <= 1'b0;
            stop_req_q <= 1'b0;
            susp_req_q <= 1'b0;
         end
         if (wr_power && wdata[`BIT_IDLE_SELECT]) begin
            idle_req_q <= 1'b1;
         end
         if (wr_power && wdata[`BIT_STOP_SELECT]) begin
            stop_req_q <= 1'b1;
         end
         if (wr_osc && wdata[`BIT_SUSPEND]) begin
            susp_req_q <= 1'b1;
         end
      end
   end

   // wake pin either-edge detect, no pending flag
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake_prev_q <= 1'b0;
         wake_irq_q <= 1'b0;
      end else begin
         wake_prev_q <= wake_pin;
         wake_irq_q <= wake_edge && mode_ctrl_q[`BIT_WAKE_INT_EN];
      end
   end
   assign wake_edge = wake_pin ^ wake_prev_q;
   assign wake_irq = wake_irq_q;

   timeout_counter #(
      .LIMIT(WD_CYC[`CNT_W-1:0])
   ) u_watchdog (
      .clk(clk),
      .nrst(nrst),
      .run(mode_ctrl_q[`BIT_WATCHDOG_EN] && (state_q != ST_STOP)),
      .kick(watchdog_kick),
      .expired(wd_expired)
   );

   timeout_counter #(
      .LIMIT(MCD_CYC[`CNT_W-1:0])
   ) u_missing_clk (
      .clk(clk),
      .nrst(nrst),
      .run(mode_ctrl_q[`BIT_MISSING_CLK_EN] && (state_q == ST_STOP)),
      .kick(1'b0),
      .expired(mcd_expired)
   );

   // internal resets are lost when the core regulator is shut in stop
   assign int_reset = (wd_expired || mcd_expired) && !stop_shutdown_q;
   assign any_reset = reset_pin || int_reset;

   // mode state machine
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (instr_done && stop_req_q) begin
               state_d = ST_STOP;
            end else if (instr_done && idle_req_q) begin
               state_d = ST_IDLE;
            end else if (instr_done && susp_req_q) begin
               state_d = ST_SUSPEND;
            end
         end
         ST_IDLE: begin
            if (irq_pending) begin
               state_d = ST_RUN;
            end
         end
         ST_STOP: begin
            state_d = ST_STOP;
         end
         ST_SUSPEND: begin
            if (wake_edge) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_RUN;
         stop_shutdown_q <= 1'b0;
         sys_reset <= 1'b0;
      end else begin
         state_q <= any_reset ? ST_RUN : state_d;
         sys_reset <= any_reset;
         if (any_reset) begin
            stop_shutdown_q <= 1'b0;
         end else if (state_q == ST_RUN && state_d == ST_STOP) begin
            stop_shutdown_q <= reg_ctrl_q[`BIT_STOP_REG_SHUTDOWN];
         end
      end
   end

   assign cpu_halt = (state_q == ST_IDLE) || (state_q == ST_STOP);
   assign periph_clk_stop = (state_q == ST_STOP);
   assign hf_osc_enable = (state_q == ST_RUN) || (state_q == ST_IDLE);
   assign fetch_addr = `RESET_VECTOR;

   // regulator drive outputs
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         usb_regulator_enable <= 1'b1;
         usb_regulator_low_power <= 1'b0;
         core_regulator_on <= 1'b1;
         core_regulator_low_power <= 1'b0;
      end else begin
         usb_regulator_enable <= !reg_ctrl_q[`BIT_USB_REG_DISABLE];
         usb_regulator_low_power <= reg_ctrl_q[`BIT_USB_REG_LOW_POWER];
         core_regulator_on <= !((state_q == ST_STOP) && stop_shutdown_q);
         // low power only honoured while the usb regulator is enabled
         core_regulator_low_power <= reg_ctrl_q[`BIT_CORE_REG_LOW_POWER] &&
            !reg_ctrl_q[`BIT_USB_REG_DISABLE];
      end
   end

   assign reg_ctrl_rd = {reg_ctrl_q[7], wake_pin, reg_ctrl_q[5:0]};
   assign power_rd = `RESET_BYTE;

   // read data one cycle after the read strobe
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= `RESET_BYTE;
      end else if (rd) begin
         case (addr)
            `ADDR_REGULATOR_CONTROL: rdata <= reg_ctrl_rd;
            `ADDR_POWER_CONTROL: rdata <= power_rd;
            `ADDR_OSCILLATOR_CONTROL: rdata <= osc_ctrl_q;
            `ADDR_MODE_CONTROL: rdata <= mode_ctrl_q;
            `ADDR_MODE_STATUS: rdata <= {6'h00, state_q};
            default: rdata <= `RESET_BYTE;
         endcase
      end else begin
         rdata <= `RESET_BYTE;
      end
   end
endmodule
`default_nettype wire

//--- power_mode_regs.vh
// constants for the power mode and regulator control block
// assumes a byte-wide register port and a 100 MHz system clock
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH

`define ADDR_REGULATOR_CONTROL 8'hc9
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_OSCILLATOR_CONTROL 8'hb2
`define ADDR_MODE_CONTROL 8'hb3
`define ADDR_MODE_STATUS 8'hb4

`define BIT_USB_REG_DISABLE 7
`define BIT_WAKE_PIN_LEVEL 6
`define BIT_USB_REG_LOW_POWER 4
`define BIT_STOP_REG_SHUTDOWN 3
`define BIT_CORE_REG_LOW_POWER 1
`define BIT_IDLE_SELECT 0
`define BIT_STOP_SELECT 1
`define BIT_SUSPEND 5
`define BIT_WATCHDOG_EN 0
`define BIT_MISSING_CLK_EN 1
`define BIT_WAKE_INT_EN 2

`define REG_CTRL_WRITE_MASK 8'h9a
`define OSC_CTRL_WRITE_MASK 8'hdf
`define RESET_BYTE 8'h00
`define RESET_VECTOR 16'h0000

`define MODE_RUN 2'h0
`define MODE_IDLE 2'h1
`define MODE_STOP 2'h2
`define MODE_SUSPEND 2'h3

`define WATCHDOG_TIMEOUT_US 100
`define MISSING_CLK_TIMEOUT_US 100
`define CLOCK_MHZ 100
`define CNT_W 16

`endif

//--- timeout_counter.v
// timeout counter that raises a reset request when it runs out
// assumes a synchronous run level from the mode controller
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_regs.vh"

module timeout_counter #(
   parameter [`CNT_W-1:0] LIMIT = 16'd10000
) (
   input wire clk,
   input wire nrst,
   input wire run,
   input wire kick,
   output wire expired
);
   reg [`CNT_W-1:0] count_q;
   reg expired_q;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= {`CNT_W{1'b0}};
         expired_q <= 1'b0;
      end else if (!run || kick) begin
         count_q <= {`CNT_W{1'b0}};
         expired_q <= 1'b0;
      end else if (count_q >= LIMIT - 16'd1) begin
         expired_q <= 1'b1;
      end else begin
         count_q <= count_q + 16'd1;
      end
   end

   assign expired = expired_q;
endmodule
`default_nettype wire

//--- cpu_model.sv
// cpu side: ends the mode setting instruction after dly cycles
// assumes the bench drives the register port and dly
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_regs.vh"
module cpu_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [3:0] dly,
   output logic instr_done
);
   logic [3:0] cnt_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 4'h0;
         instr_done <= 1'b0;
      end else begin
         instr_done <= cnt_q == 4'h1;
         if (wr && (addr == `ADDR_POWER_CONTROL || addr == `ADDR_OSCILLATOR_CONTROL))
            cnt_q <= dly;
         else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- power_mode_ctrl_sva.sv
// checker on the power mode block ports
// assumes one clock domain and active low reset
`timescale 1ns/1ps
`default_nettype none
module power_mode_ctrl_sva (
   input wire clk,
   input wire nrst,
   input wire [7:0] addr,
   input wire rd,
   input wire [7:0] rdata,
   input wire irq_pending,
   input wire wake_pin,
   input wire reset_pin,
   input wire cpu_halt,
   input wire periph_clk_stop,
   input wire hf_osc_enable,
   input wire usb_regulator_enable,
   input wire usb_regulator_low_power,
   input wire core_regulator_low_power,
   input wire sys_reset,
   input wire [15:0] fetch_addr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_restart_zero: assert property (fetch_addr == 16'h0000)
      else $error("restart address not zero");
   a_pin_reset: assert property (reset_pin |=> sys_reset)
      else $error("reset pin ignored");
   a_stop_halts: assert property (periph_clk_stop |-> cpu_halt && !hf_osc_enable)
      else $error("stop without halt");
   a_stop_exit: assert property ($fell(periph_clk_stop) |-> sys_reset)
      else $error("stop left without reset");
   a_idle_wake: assert property (cpu_halt && !periph_clk_stop && irq_pending |=> !cpu_halt)
      else $error("idle not woken");
   a_select_zero: assert property (rd && addr == 8'h87 |=> rdata == 8'h00)
      else $error("select bits read nonzero");
   a_pin_level: assert property (rd && addr == 8'hc9 |=> rdata[6] == $past(wake_pin))
      else $error("wake level wrong");
   a_reserved_zero: assert property (rd && addr == 8'hc9 |=> {rdata[5], rdata[2], rdata[0]} == 3'h0)
      else $error("reserved bit set");
   a_usb_bits: assert property (rd && addr == 8'hc9 |=>
      rdata[7] != usb_regulator_enable && rdata[4] == usb_regulator_low_power)
      else $error("usb regulator outputs wrong");
   a_core_gate: assert property (core_regulator_low_power |-> usb_regulator_enable)
      else $error("core low power while usb off");
   a_wake_end: assert property (!hf_osc_enable && !cpu_halt && $changed(wake_pin)
      |-> ##[1:2] hf_osc_enable)
      else $error("suspend not ended");
endmodule
bind power_mode_ctrl power_mode_ctrl_sva chk (.clk(clk), .nrst(nrst), .addr(addr), .rd(rd),
   .rdata(rdata), .irq_pending(irq_pending), .wake_pin(wake_pin), .reset_pin(reset_pin),
   .cpu_halt(cpu_halt), .periph_clk_stop(periph_clk_stop), .hf_osc_enable(hf_osc_enable),
   .usb_regulator_enable(usb_regulator_enable), .usb_regulator_low_power(usb_regulator_low_power),
   .core_regulator_low_power(core_regulator_low_power), .sys_reset(sys_reset),
   .fetch_addr(fetch_addr));
`default_nettype wire

//--- tb_power_mode_ctrl.sv
// bench: register port, idle, stop and suspend entry and exit
// assumes cpu_model answers each mode write with instr_done
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_regs.vh"
module tb_power_mode_ctrl;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, irq = 0, wpin = 0, rpin = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, d, v;
   logic [3:0] dly = 4'h8;
   wire [7:0] rdata;
   wire [15:0] fa;
   wire done, halt, pstop, osc, ue, ulp, con, clp, wirq, srst;
   wire [3:0] sig = {wirq, osc, srst, halt};
   int bad_count = 0, samples_checked = 0;
   power_mode_ctrl uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .instr_done(done), .irq_pending(irq), .wake_pin(wpin), .reset_pin(rpin),
      .watchdog_kick(1'b0), .cpu_halt(halt), .periph_clk_stop(pstop), .hf_osc_enable(osc),
      .usb_regulator_enable(ue), .usb_regulator_low_power(ulp), .core_regulator_on(con),
      .core_regulator_low_power(clp), .wake_irq(wirq), .sys_reset(srst), .fetch_addr(fa));
   cpu_model cpu (.clk(clk), .nrst(nrst), .wr(wr), .addr(addr), .dly(dly), .instr_done(done));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_sig(input int s, input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
         if (n > 12000) begin
            chk(16'h0, 16'h1);
            complete_run();
         end
      end while (sig[s] !== lvl);
   endtask
   initial begin
      void'($urandom(86309));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      get(`ADDR_REGULATOR_CONTROL);
      chk(d, `RESET_BYTE);
      chk({ue, con, ulp, clp}, 4'hc);
      for (int i = 0; i < 12; i++) begin
         v = (i == 0) ? 8'hff : 8'($urandom);
         v[1] = v[1] & ~v[7];
         wpin <= 1'($urandom);
         put(`ADDR_REGULATOR_CONTROL, v);
         get(`ADDR_REGULATOR_CONTROL);
         chk(d, (v & `REG_CTRL_WRITE_MASK) | {wpin, 6'h00});
         chk({ue, ulp, clp}, {~v[7], v[4], v[1]});
      end
      get(8'h10);
      chk(d, 8'h00);
      put(`ADDR_POWER_CONTROL, 8'h01);
      wait_sig(0, 1'b1);
      repeat (20) @(posedge clk);
      #1 chk({halt, pstop, osc}, 3'h5);
      get(`ADDR_MODE_STATUS);
      chk(d, {6'h00, `MODE_IDLE});
      irq <= 1'b1;
      wait_sig(0, 1'b0);
      irq <= 1'b0;
      get(`ADDR_POWER_CONTROL);
      chk(d, 8'h00);
      put(`ADDR_MODE_CONTROL, 8'h01);
      put(`ADDR_POWER_CONTROL, 8'h01);
      wait_sig(1, 1'b1);
      chk(fa, `RESET_VECTOR);
      dly <= 4'h1;
      put(`ADDR_POWER_CONTROL, 8'h02);
      wait_sig(0, 1'b1);
      irq <= 1'b1;
      repeat (30) @(posedge clk);
      #1 chk({halt, pstop, osc}, 3'h6);
      get(`ADDR_MODE_STATUS);
      chk(d, {6'h00, `MODE_STOP});
      irq <= 1'b0;
      rpin <= 1'b1;
      wait_sig(1, 1'b1);
      rpin <= 1'b0;
      chk(halt, 1'b0);
      put(`ADDR_MODE_CONTROL, 8'h02);
      put(`ADDR_POWER_CONTROL, 8'h02);
      wait_sig(1, 1'b1);
      put(`ADDR_MODE_CONTROL, 8'h02);
      put(`ADDR_REGULATOR_CONTROL, 8'h08);
      put(`ADDR_POWER_CONTROL, 8'h02);
      wait_sig(0, 1'b1);
      repeat (11000) @(posedge clk);
      #1 chk({halt, srst, con}, 3'h4);
      rpin <= 1'b1;
      wait_sig(1, 1'b1);
      rpin <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(con, 1'b1);
      put(`ADDR_REGULATOR_CONTROL, 8'h02);
      put(`ADDR_MODE_CONTROL, 8'h04);
      repeat (12) @(posedge clk);
      put(`ADDR_OSCILLATOR_CONTROL, 8'h20);
      wait_sig(2, 1'b0);
      chk(halt, 1'b0);
      get(`ADDR_MODE_STATUS);
      chk(d, {6'h00, `MODE_SUSPEND});
      wpin <= ~wpin;
      wait_sig(3, 1'b1);
      chk(osc, 1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
